//--- logic/bfs_defines.svh
// Constants of the block floating-point scaler: widths, thresholds, register map
`ifndef BFS_DEFINES_SVH
`define BFS_DEFINES_SVH

`define BFS_WORD_W        24
`define BFS_ACC_W         60
`define BFS_ACC_LSB       23
`define BFS_TOP_W         5
`define BFS_SQ_W          10
`define BFS_CODE_W        3
`define BFS_EXP_W         6
`define BFS_WORD_MAX      24'h7fffff
`define BFS_WORD_MIN      24'h800000

`define BFS_THR_CODE5     10'h101
`define BFS_THR_CODE4     10'h040
`define BFS_THR_CODE3     10'h010
`define BFS_THR_CODE2     10'h004
`define BFS_THR_CODE1     10'h001
`define BFS_AUTO_MAX      3'h5

`define BFS_ADDR_W        4
`define BFS_DATA_W        32
`define BFS_REG_CTRL      4'h0
`define BFS_REG_STATUS    4'h4
`define BFS_CTRL_RADIX_LSB 0
`define BFS_CTRL_CLEAR_BIT 8
`define BFS_STAT_MAX_LSB  0
`define BFS_STAT_SHIFT_LSB 4
`define BFS_STAT_EXP_LSB  8
`define BFS_RADIX_FLD_R2  2'h0
`define BFS_RADIX_FLD_R4  2'h1
`define BFS_RADIX_FLD_R16 2'h2
`define BFS_CTRL_RESET    2'h0

`endif

//--- logic/bfs_pkg.sv
// Types shared by the block floating-point scaler modules
`include "bfs_defines.svh"
package bfs_pkg;
  typedef enum logic [1:0] {BFS_R2, BFS_R4, BFS_R16} bfs_radix_e;
  typedef logic signed [`BFS_WORD_W-1:0] bfs_word_t;
  typedef logic [`BFS_CODE_W-1:0]        bfs_code_t;
endpackage : bfs_pkg

//--- logic/bfs_mag_if.sv
// Link between the scaler top and its magnitude-to-code unit
`timescale 1ns/100ps
`include "bfs_defines.svh"
interface bfs_mag_if;
  logic                   valid;
  logic [`BFS_TOP_W-1:0]  re_top;
  logic [`BFS_TOP_W-1:0]  im_top;
  logic                   code_valid;
  bfs_pkg::bfs_code_t     code;
  modport feeder (output valid, output re_top, output im_top, input code_valid, input code);
  modport unit   (input valid, input re_top, input im_top, output code_valid, output code);
endinterface : bfs_mag_if

//--- logic/bfs_mag_code.sv
// Magnitude estimate of one complex result mapped to a stage scale code
`timescale 1ns/100ps
`include "bfs_defines.svh"
module bfs_mag_code (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  bfs_mag_if.unit  mag
);

  logic [`BFS_TOP_W-1:0] re_abs;
  logic [`BFS_TOP_W-1:0] im_abs;
  logic [`BFS_SQ_W-1:0]  sum_sq;
  bfs_pkg::bfs_code_t    code_reg;
  bfs_pkg::bfs_code_t    code_next;
  logic                  code_valid_reg;
  logic                  code_valid_next;

  // Magnitude of a signed five-bit field; the most negative value gives 16
  function automatic logic [`BFS_TOP_W-1:0] top_abs(input logic [`BFS_TOP_W-1:0] x);
    top_abs = x[`BFS_TOP_W-1] ? `BFS_TOP_W'(~x + 5'h01) : x;
  endfunction : top_abs

  // Squared thresholds stand in for the square root, so no root hardware
  always_comb begin
    re_abs = top_abs(mag.re_top);
    im_abs = top_abs(mag.im_top);
    sum_sq = `BFS_SQ_W'({5'h00, re_abs} * {5'h00, re_abs}) +
             `BFS_SQ_W'({5'h00, im_abs} * {5'h00, im_abs});
    code_next       = code_reg;
    code_valid_next = 1'b0;
    if (mag.valid) begin
      code_valid_next = 1'b1;
      if (sum_sq >= `BFS_THR_CODE5)      code_next = 3'h5;
      else if (sum_sq >= `BFS_THR_CODE4) code_next = 3'h4;
      else if (sum_sq >= `BFS_THR_CODE3) code_next = 3'h3;
      else if (sum_sq >= `BFS_THR_CODE2) code_next = 3'h2;
      else if (sum_sq >= `BFS_THR_CODE1) code_next = 3'h1;
      else                               code_next = 3'h0;
    end
  end

  // Code register, frozen while the clock enable is low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg       <= 3'h0;
      code_valid_reg <= 1'b0;
    end else if (ce) begin
      code_reg       <= code_next;
      code_valid_reg <= code_valid_next;
    end
  end

  assign mag.code       = code_reg;
  assign mag.code_valid = code_valid_reg;

  // Most negative real half alone is exactly one and gives code 4; any imaginary part lifts it to 5
  sequence s_fed;
    ce && mag.valid;
  endsequence

  full_scale_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_fed and (mag.re_top == 5'h10) && (mag.im_top != 5'h00) |=> (mag.code == 3'h5) && mag.code_valid)
    else $error("Full-scale result did not give code 5");

  just_below_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_fed and (mag.re_top == 5'h0f) && (mag.im_top == 5'h04) |=> mag.code == 3'h4)
    else $error("Magnitude just under one did not give code 4");

  small_mag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_fed and (mag.re_top == 5'h1f) && (mag.im_top == 5'h00) |=> mag.code == 3'h1)
    else $error("Magnitude of one sixteenth did not give code 1");

endmodule : bfs_mag_code

//--- logic/bfs_scaler.sv
// Block floating-point scaler: input shifting, output scale code, exponent total
//
// Notes on behaviour
// - Complex words, 24-bit signed real and imaginary.
// - 60-bit results rounded once to 24 bits.
// - Magnitude from top five bits of each half.
// - Magnitude maps to scale code zero to five.
// - Keep running maximum code, drive scale-out pins.
// - Stage maximum is next stage's scaling reference.
// - Select high: shift right by scale-in, 0-7.
// - Select low: automatic shift, never above five.
// - Automatic shift from code and instruction radix.
// - Exponent out is exponent in plus shift.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "bfs_defines.svh"
module bfs_scaler (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  input  wire logic [`BFS_ADDR_W-1:0]   reg_addr,
  input  wire logic [`BFS_DATA_W-1:0]   reg_wr_data,
  input  wire logic                     reg_wr_stb,
  input  wire logic                     reg_rd_stb,
  output logic      [`BFS_DATA_W-1:0]   reg_rd_data,
  input  wire logic                     in_valid,
  input  wire logic [`BFS_WORD_W-1:0]   in_re,
  input  wire logic [`BFS_WORD_W-1:0]   in_im,
  output logic                          shifted_valid,
  output logic      [`BFS_WORD_W-1:0]   shifted_re,
  output logic      [`BFS_WORD_W-1:0]   shifted_im,
  input  wire logic                     scale_source_select,
  input  wire logic [`BFS_CODE_W-1:0]   stage_scale_code_in,
  input  wire logic [`BFS_EXP_W-1:0]    exponent_total_in,
  output logic      [`BFS_EXP_W-1:0]    exponent_total_out,
  input  wire logic                     acc_valid,
  input  wire logic [`BFS_ACC_W-1:0]    acc_re,
  input  wire logic [`BFS_ACC_W-1:0]    acc_im,
  output logic                          out_valid,
  output logic      [`BFS_WORD_W-1:0]   out_re,
  output logic      [`BFS_WORD_W-1:0]   out_im,
  output logic      [`BFS_CODE_W-1:0]   stage_scale_code_out
);

  localparam int ACC_HI = `BFS_ACC_LSB + `BFS_WORD_W - 1;

  // Control and register port state
  bfs_pkg::bfs_radix_e      radix_reg;
  bfs_pkg::bfs_radix_e      radix_next;
  logic [1:0]               radix_fld;
  logic                     pass_clear;
  logic [`BFS_DATA_W-1:0]   rd_data_reg;
  logic [`BFS_DATA_W-1:0]   rd_data_next;

  // Input side state
  logic [`BFS_CODE_W-1:0]   code_sat;
  logic [`BFS_CODE_W-1:0]   auto_shift;
  logic [`BFS_CODE_W-1:0]   shift_amt;
  logic                     sh_valid_reg;
  logic                     sh_valid_next;
  bfs_pkg::bfs_word_t       sh_re_reg;
  bfs_pkg::bfs_word_t       sh_re_next;
  bfs_pkg::bfs_word_t       sh_im_reg;
  bfs_pkg::bfs_word_t       sh_im_next;
  logic [`BFS_EXP_W-1:0]    exp_reg;
  logic [`BFS_EXP_W-1:0]    exp_next;

  // Output side state
  logic                     res_valid_reg;
  logic                     res_valid_next;
  logic [`BFS_WORD_W-1:0]   res_re_reg;
  logic [`BFS_WORD_W-1:0]   res_re_next;
  logic [`BFS_WORD_W-1:0]   res_im_reg;
  logic [`BFS_WORD_W-1:0]   res_im_next;
  bfs_pkg::bfs_code_t       max_reg;
  bfs_pkg::bfs_code_t       max_next;

  bfs_mag_if mag ();

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Round once at the output word; saturate instead of wrapping on overflow
  function automatic logic [`BFS_WORD_W-1:0] round_sat(input logic [`BFS_ACC_W-1:0] acc);
    logic [`BFS_ACC_W-1:0] sum;
    sum = acc + (`BFS_ACC_W'(1) << (`BFS_ACC_LSB - 1));
    if (sum[`BFS_ACC_W-1:ACC_HI] == {(`BFS_ACC_W - ACC_HI){sum[ACC_HI]}})
      round_sat = sum[ACC_HI:`BFS_ACC_LSB];
    else if (acc[`BFS_ACC_W-1])
      round_sat = `BFS_WORD_MIN;
    else
      round_sat = `BFS_WORD_MAX;
  endfunction : round_sat

  // Register port: control holds the radix, a write-one bit starts a new pass
  always_comb begin
    radix_next   = radix_reg;
    pass_clear   = 1'b0;
    rd_data_next = '0;
    radix_fld    = reg_wr_data[`BFS_CTRL_RADIX_LSB +: 2];
    if (reg_wr_stb && (reg_addr == `BFS_REG_CTRL)) begin
      pass_clear = reg_wr_data[`BFS_CTRL_CLEAR_BIT];
      case (radix_fld)
        `BFS_RADIX_FLD_R4:  radix_next = bfs_pkg::BFS_R4;
        `BFS_RADIX_FLD_R16: radix_next = bfs_pkg::BFS_R16;
        default:            radix_next = bfs_pkg::BFS_R2;
      endcase
    end
    if (reg_rd_stb) begin
      case (reg_addr)
        `BFS_REG_CTRL: begin
          case (radix_reg)
            bfs_pkg::BFS_R4:  rd_data_next[`BFS_CTRL_RADIX_LSB +: 2] = `BFS_RADIX_FLD_R4;
            bfs_pkg::BFS_R16: rd_data_next[`BFS_CTRL_RADIX_LSB +: 2] = `BFS_RADIX_FLD_R16;
            default:          rd_data_next[`BFS_CTRL_RADIX_LSB +: 2] = `BFS_RADIX_FLD_R2;
          endcase
        end
        `BFS_REG_STATUS: begin
          rd_data_next[`BFS_STAT_MAX_LSB +: `BFS_CODE_W]   = max_reg;
          rd_data_next[`BFS_STAT_SHIFT_LSB +: `BFS_CODE_W] = shift_amt;
          rd_data_next[`BFS_STAT_EXP_LSB +: `BFS_EXP_W]    = exp_reg;
        end
        default: rd_data_next = '0;                                   // Unmapped reads as zero
      endcase
    end
  end

  // Register port flops; accesses made while ce is low are lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      radix_reg   <= bfs_pkg::BFS_R2;
      rd_data_reg <= '0;
    end else if (ce) begin
      radix_reg   <= radix_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign reg_rd_data = rd_data_reg;

  // Automatic shift: codes above five count as five, so the shift stays bounded
  always_comb begin
    code_sat = (stage_scale_code_in > `BFS_AUTO_MAX) ? `BFS_AUTO_MAX : stage_scale_code_in;
    case (radix_reg)
      bfs_pkg::BFS_R2:  auto_shift = (code_sat >= 3'h4) ? 3'(code_sat - 3'h3) : 3'h0;
      bfs_pkg::BFS_R4:  auto_shift = (code_sat >= 3'h3) ? 3'(code_sat - 3'h2) : 3'h0;
      bfs_pkg::BFS_R16: auto_shift = code_sat;
      default:          auto_shift = 3'h0;
    endcase
    // The scale-in code is the previous stage's maximum in automatic mode
    shift_amt = scale_source_select ? stage_scale_code_in : auto_shift;
  end

  // Input words are shifted arithmetically; the exponent total tracks the shift
  always_comb begin
    sh_valid_next = in_valid;
    sh_re_next    = sh_re_reg;
    sh_im_next    = sh_im_reg;
    if (in_valid) begin
      sh_re_next = $signed(in_re) >>> shift_amt;
      sh_im_next = $signed(in_im) >>> shift_amt;
    end
    exp_next = exponent_total_in + {3'h0, shift_amt};
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_valid_reg <= 1'b0;
      sh_re_reg    <= '0;
      sh_im_reg    <= '0;
      exp_reg      <= '0;
    end else if (ce) begin
      sh_valid_reg <= sh_valid_next;
      sh_re_reg    <= sh_re_next;
      sh_im_reg    <= sh_im_next;
      exp_reg      <= exp_next;
    end
  end

  assign shifted_valid      = sh_valid_reg;
  assign shifted_re         = sh_re_reg;
  assign shifted_im         = sh_im_reg;
  assign exponent_total_out = exp_reg;

  // Results enter wide and leave as 24-bit words; this is the only rounding step
  always_comb begin
    res_valid_next = acc_valid;
    res_re_next    = res_re_reg;
    res_im_next    = res_im_reg;
    if (acc_valid) begin
      res_re_next = round_sat(acc_re);
      res_im_next = round_sat(acc_im);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid_reg <= 1'b0;
      res_re_reg    <= '0;
      res_im_reg    <= '0;
    end else if (ce) begin
      res_valid_reg <= res_valid_next;
      res_re_reg    <= res_re_next;
      res_im_reg    <= res_im_next;
    end
  end

  assign out_valid = res_valid_reg;
  assign out_re    = res_re_reg;
  assign out_im    = res_im_reg;

  // Top five bits of each delivered word go to the magnitude unit
  assign mag.valid  = res_valid_reg;
  assign mag.re_top = res_re_reg[`BFS_WORD_W-1 -: `BFS_TOP_W];
  assign mag.im_top = res_im_reg[`BFS_WORD_W-1 -: `BFS_TOP_W];

  bfs_mag_code u_mag (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .mag     (mag.unit)
  );

  // Running maximum; a code arriving with the pass clear still counts
  always_comb begin
    max_next = max_reg;
    if (pass_clear)
      max_next = 3'h0;
    if (mag.code_valid && (pass_clear || (mag.code > max_reg)))
      max_next = mag.code;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      max_reg <= 3'h0;
    else if (ce)
      max_reg <= max_next;
  end

  assign stage_scale_code_out = max_reg;

  sequence s_user_word;
    ce && in_valid && scale_source_select;
  endsequence

  sequence s_result_in;
    ce && acc_valid;
  endsequence

  sequence s_new_code;
    ce && mag.code_valid && !pass_clear;
  endsequence

  user_shift_a: assert property (s_user_word |=> shifted_valid &&
    ($signed(shifted_re) == ($signed($past(in_re)) >>> $past(stage_scale_code_in))))
    else $error("User-mode shift does not match the scale-in value");

  auto_bound_a: assert property (!scale_source_select |-> shift_amt <= 3'h5)
    else $error("Automatic shift above five");

  auto_radix_a: assert property (!scale_source_select && (radix_reg == bfs_pkg::BFS_R4) &&
    (stage_scale_code_in == 3'h5) |-> shift_amt == 3'h3)
    else $error("Radix-4 code 5 did not give a shift of 3");

  auto_r2_a: assert property (!scale_source_select && (radix_reg == bfs_pkg::BFS_R2) &&
    (stage_scale_code_in == 3'h3) |-> shift_amt == 3'h0)
    else $error("Radix-2 code 3 did not give zero shift");

  exp_total_a: assert property (ce |=>
    exponent_total_out == `BFS_EXP_W'($past(exponent_total_in) + $past(shift_amt)))
    else $error("Exponent total is not input plus shift");

  result_path_a: assert property (s_result_in |=> (out_valid and (ce |=> mag.code_valid)))
    else $error("Result did not reach the code unit in time");

  round_sat_a: assert property (s_result_in and (!acc_re[`BFS_ACC_W-1] && (|acc_re[`BFS_ACC_W-2:ACC_HI]))
    |=> out_re == `BFS_WORD_MAX)
    else $error("Positive overflow did not saturate");

  max_rise_a: assert property (s_new_code and (mag.code > max_reg) |=>
    stage_scale_code_out == $past(mag.code))
    else $error("Larger code did not replace the maximum");

  max_keep_a: assert property (ce && !pass_clear |=> stage_scale_code_out >= $past(max_reg))
    else $error("Maximum fell without a pass clear");

  pass_clear_a: assert property (ce && pass_clear && !mag.code_valid |=> stage_scale_code_out == 3'h0)
    else $error("Pass clear did not zero the maximum");

endmodule : bfs_scaler

//--- test/bfs_stage_loop.sv
// Model of the surrounding system that feeds scale code and exponent back into a stage
`timescale 1ns/100ps
module bfs_stage_loop (
  input  wire logic       code_loop,
  input  wire logic       exp_loop,
  input  wire logic [2:0] code_user,
  input  wire logic [5:0] exp_user,
  input  wire logic [2:0] code_back,
  input  wire logic [5:0] exp_back,
  output logic      [2:0] code_in,
  output logic      [5:0] exp_in
);
  // Feedback wiring; user values stand in for the first stage of a transform
  assign code_in = code_loop ? code_back : code_user;
  assign exp_in  = exp_loop ? exp_back : exp_user;
endmodule : bfs_stage_loop

//--- test/bfs_scaler_test.sv
// Self-checking bench of the block floating-point scaler
`timescale 1ns/100ps
`include "bfs_defines.svh"
module bfs_scaler_test;
  logic        ref_clk, rst_n, ce, reg_wr_stb, reg_rd_stb, rd_due, in_valid, shifted_valid;
  logic        scale_source_select, acc_valid, out_valid, code_loop, exp_loop;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wr_data, reg_rd_data;
  logic [23:0] in_re, in_im, shifted_re, shifted_im, out_re, out_im;
  logic [2:0]  code_in, code_user, stage_scale_code_out, exp_max;
  logic [5:0]  exp_in, exp_user, exponent_total_out, e0;
  logic [59:0] acc_re, acc_im;
  logic [1:0]  radix;
  logic [53:0] shq[$];
  logic [47:0] outq[$];
  logic [31:0] rdq[$];
  logic [53:0] se;
  logic [47:0] oe;
  int          mismatches, cmp_count;
  // Top-five values of the running-maximum scenario, real and imaginary
  int          tops[9] = '{2, 1, 8, 4, 0, -16, -1, 15, -16};
  int          ims[9]  = '{0, 0, 0, 0, 0, 0, 0, 4, 1};

  bfs_scaler bfs_scaler_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data),
    .in_valid(in_valid), .in_re(in_re), .in_im(in_im), .shifted_valid(shifted_valid),
    .shifted_re(shifted_re), .shifted_im(shifted_im), .scale_source_select(scale_source_select),
    .stage_scale_code_in(code_in), .exponent_total_in(exp_in), .exponent_total_out(exponent_total_out),
    .acc_valid(acc_valid), .acc_re(acc_re), .acc_im(acc_im), .out_valid(out_valid), .out_re(out_re),
    .out_im(out_im), .stage_scale_code_out(stage_scale_code_out));
  bfs_stage_loop bfs_stage_loop_inst (.code_loop(code_loop), .exp_loop(exp_loop), .code_user(code_user),
    .exp_user(exp_user), .code_back(stage_scale_code_out), .exp_back(exponent_total_out),
    .code_in(code_in), .exp_in(exp_in));

  // Free-running 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expd);
    cmp_count++;
    if (seen !== expd) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, expd, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // Round half up at bit 22, then clamp to the signed 24-bit range
  function automatic logic [23:0] rnd24(input logic [59:0] a);
    logic signed [60:0] t;
    t = ($signed({a[59], a}) + 61'sh400000) >>> 23;
    if (t > 61'sh7fffff) return 24'h7fffff;
    if (t < -61'sh800000) return 24'h800000;
    return t[23:0];
  endfunction : rnd24

  // Squared sum of top five bits against squared thresholds, in 1/256 units
  function automatic logic [2:0] code_of(input logic [23:0] re, input logic [23:0] im);
    int r, i, s;
    r = $signed(re[23:19]);
    i = $signed(im[23:19]);
    s = r * r + i * i;
    if (s >= `BFS_THR_CODE5) return 3'h5;
    if (s >= `BFS_THR_CODE4) return 3'h4;
    if (s >= `BFS_THR_CODE3) return 3'h3;
    if (s >= `BFS_THR_CODE2) return 3'h2;
    return (s >= `BFS_THR_CODE1) ? 3'h1 : 3'h0;
  endfunction : code_of

  // Automatic shift by radix; codes above five saturate so the shift stays at five or less
  function automatic logic [2:0] auto_sh(input logic [1:0] rad, input logic [2:0] c);
    logic [2:0] k;
    k = (c > 3'h5) ? 3'h5 : c;
    if (rad == 2'h2) return k;
    if (rad == 2'h1) return (k >= 3'h3) ? k - 3'h2 : 3'h0;
    return (k >= 3'h4) ? k - 3'h3 : 3'h0;
  endfunction : auto_sh

  function automatic logic [59:0] top_acc(input int t);
    return 60'(t) << 42;
  endfunction : top_acc

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_stb <= 1'b1;
    @(posedge ref_clk);
    reg_wr_stb <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd_stb <= 1'b1;
    rdq.push_back(e);
    @(posedge ref_clk);
    reg_rd_stb <= 1'b0;
  endtask : reg_rd

  // Leaves in_valid high so consecutive calls stream one word a cycle
  task automatic send_in(input logic [23:0] re, input logic [23:0] im, input logic sel, input logic [2:0] code,
                         input logic [5:0] ex);
    logic [2:0] sh;
    sh = sel ? code : auto_sh(radix, code);
    @(posedge ref_clk);
    in_valid <= 1'b1;
    in_re <= re;
    in_im <= im;
    scale_source_select <= sel;
    code_user <= code;
    exp_user <= ex;
    shq.push_back({24'($signed(re) >>> sh), 24'($signed(im) >>> sh), 6'(ex + 6'(sh))});
  endtask : send_in

  task automatic in_off;
    @(posedge ref_clk);
    in_valid <= 1'b0;
  endtask : in_off

  task automatic send_acc(input logic [59:0] a, input logic [59:0] b);
    logic [2:0] c;
    c = code_of(rnd24(a), rnd24(b));
    if (c > exp_max) exp_max = c;
    outq.push_back({rnd24(a), rnd24(b)});
    @(posedge ref_clk);
    acc_valid <= 1'b1;
    acc_re <= a;
    acc_im <= b;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
  endtask : send_acc

  task automatic max_is;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check("stage_scale_code_out", stage_scale_code_out, exp_max);
  endtask : max_is

  // Result monitor: read data only in the cycle after a read strobe
  always @(posedge ref_clk) rd_due <= reg_rd_stb;
  always @(negedge ref_clk) begin
    if (rd_due === 1'b1) check("reg_rd_data", reg_rd_data, rdq.pop_front());
    if (shifted_valid === 1'b1) begin
      se = shq.pop_front();
      check("shifted_re", shifted_re, se[53:30]);
      check("shifted_im", shifted_im, se[29:6]);
      check("exponent_total_out", exponent_total_out, se[5:0]);
    end
    if (out_valid === 1'b1) begin
      oe = outq.pop_front();
      check("out_re", out_re, oe[47:24]);
      check("out_im", out_im, oe[23:0]);
    end
  end

  // Watchdog cuts a hang short
  initial begin
    #(25 * 4000);
    mismatches++;
    wrap_up();
  end

  // Main sequence
  initial begin
    {rst_n, reg_wr_stb, reg_rd_stb, in_valid, acc_valid, code_loop, exp_loop} = '0;
    {reg_addr, reg_wr_data, in_re, in_im, acc_re, acc_im, code_user, exp_user, e0} = '0;
    {scale_source_select, radix, exp_max} = '0;
    ce = 1'b1;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(32'h9f4254a0));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_rd(`BFS_REG_CTRL, 32'h0);
    reg_rd(`BFS_REG_STATUS, 32'h0);
    reg_wr(4'h8, 32'hffffffff);
    reg_wr(`BFS_REG_STATUS, 32'hffffffff);
    reg_rd(4'h8, 32'h0);
    reg_rd(`BFS_REG_CTRL, 32'h0);
    // Every radix setting against every incoming code, automatic mode
    for (int r = 0; r < 4; r++) begin
      reg_wr(`BFS_REG_CTRL, 32'(r));
      radix = (r == 3) ? 2'h0 : 2'(r);
      reg_rd(`BFS_REG_CTRL, 32'(radix));
      for (int c = 0; c < 8; c++) send_in(24'($urandom), 24'($urandom), 1'b0, 3'(c), 6'($urandom));
      in_off();
    end
    // User mode, all shifts, with the most negative word and exponent wrap
    send_in(24'h800000, 24'h7fffff, 1'b1, 3'h7, 6'h3f);
    for (int c = 0; c < 8; c++) send_in(24'($urandom), 24'($urandom), 1'b1, 3'(c), 6'h3c);
    in_off();
    reg_rd(`BFS_REG_STATUS, {18'h0, 6'h03, 1'b0, 3'h7, 1'b0, exp_max});
    // Running maximum over codes out of order, then random results
    for (int i = 0; i < 9; i++) begin
      send_acc(top_acc(tops[i]), top_acc(ims[i]));
      max_is();
    end
    reg_wr(`BFS_REG_CTRL, 32'h100);
    exp_max = 3'h0;
    max_is();
    for (int i = 0; i < 20; i++) begin
      send_acc(60'($signed({$urandom, $urandom}) >>> ($urandom % 24)),
               60'($signed({$urandom, $urandom}) >>> ($urandom % 24)));
    end
    max_is();
    // Stage maximum looped back as the next stage's scale-in, radix-16
    reg_wr(`BFS_REG_CTRL, 32'h102);
    radix = 2'h2;
    exp_max = 3'h0;
    send_acc(top_acc(4), top_acc(0));
    max_is();
    @(posedge ref_clk);
    code_loop <= 1'b1;
    send_in(24'($urandom), 24'($urandom), 1'b0, exp_max, 6'h05);
    in_off();
    // Exponent looped back grows by the shift every cycle
    code_loop <= 1'b0;
    code_user <= 3'h2;
    scale_source_select <= 1'b1;
    exp_loop <= 1'b1;
    repeat (2) @(negedge ref_clk);
    e0 = exponent_total_out;
    repeat (5) @(negedge ref_clk);
    check("exponent_total_out", exponent_total_out, 6'(e0 + 6'd10));
    repeat (4) @(posedge ref_clk);
    check("pending", 32'(shq.size() + outq.size() + rdq.size()), 32'h0);
    wrap_up();
  end
endmodule : bfs_scaler_test
